/* File: design/sfd_chk_if.sv */
// carrier between the decoder and its special-encoding checker
`timescale 1ns/1ps
interface sfd_chk_if;
   logic [31:0] instr;
   logic        fp16Present;
   logic        endianUndef;
   logic        recipUndef;
   logic        ditSubset1;
   logic        ditSubset2;

   modport check
   (
      input  instr,
      input  fp16Present,
      output endianUndef,
      output recipUndef,
      output ditSubset1,
      output ditSubset2
   );

   modport host
   (
      output instr,
      output fp16Present,
      input  endianUndef,
      input  recipUndef,
      input  ditSubset1,
      input  ditSubset2
   );
endinterface

/* File: design/sfd_pkg.sv */
// constants and types shared by the instruction class decoder
package sfd_pkg;

   // decode groups presented to the execute stage
   typedef enum logic [3:0] {
      SFD_GRP_OTHER       = 4'h0,
      SFD_GRP_MISC        = 4'h1,
      SFD_GRP_SIMD_DP     = 4'h2,
      SFD_GRP_HINT_BAR    = 4'h3,
      SFD_GRP_SIMD_LDST   = 4'h4,
      SFD_GRP_UNALLOC     = 4'h5,
      SFD_GRP_SYS_LDST64  = 4'h6,
      SFD_GRP_FP_DP       = 4'h7,
      SFD_GRP_XFER32      = 4'h8,
      SFD_GRP_ADD_SIMD_FP = 4'h9,
      SFD_GRP_UNC_SIMD_FP = 4'hA,
      SFD_GRP_SVC         = 4'hB
   } sfd_group_t;

   // register offsets on the software port (byte addresses)
   localparam logic [3:0] SFD_OFF_CTRL   = 4'h0;
   localparam logic [3:0] SFD_OFF_STATUS = 4'h4;
   localparam logic [3:0] SFD_OFF_UNDEF  = 4'h8;

   // control register fields
   localparam int SFD_CTRL_FP16_BIT = 0;
   localparam int SFD_CTRL_MODE_BIT = 1;
   localparam logic [1:0] SFD_CTRL_RESET = 2'h0;

   // status register fields
   localparam int SFD_STAT_GRP_LSB   = 0;
   localparam int SFD_STAT_UNDEF_BIT = 4;
   localparam int SFD_STAT_DIT_BIT   = 5;
   localparam int SFD_STAT_VALID_BIT = 6;

   // undefined-instruction counter
   localparam int SFD_UNDEF_CNT_W = 16;
   localparam logic [15:0] SFD_UNDEF_CNT_RESET = 16'h0000;

   // instruction field positions
   localparam int SFD_COND_MSB     = 31;
   localparam int SFD_COND_LSB     = 28;
   localparam logic [3:0] SFD_COND_ALWAYS = 4'hF;
   localparam int SFD_UNC_PRI_MSB  = 26;
   localparam int SFD_UNC_PRI_LSB  = 24;
   localparam int SFD_UNC_SEC_BIT  = 20;
   localparam int SFD_SYS_PRI_MSB  = 25;
   localparam int SFD_SYS_PRI_LSB  = 24;
   localparam int SFD_SYS_TER_MSB  = 11;
   localparam int SFD_SYS_TER_LSB  = 10;
   localparam int SFD_SYS_QUA_BIT  = 4;
   localparam int SFD_ALT_PRI_BIT  = 28;

endpackage

/* File: design/sfd_special_check.sv */
// checks of single encodings: endian set, estimates, timing subsets
`timescale 1ns/1ps
module sfd_special_check
(
   sfd_chk_if.check chk
);
   logic [31:0] ins;
   logic [1:0]  size;
   logic        isEndianSet;
   logic        isRecipEst;
   logic        isMiscCmp;
   logic        isMlaScalar;
   logic        isAbdInt;

   assign ins  = chk.instr;
   assign size = ins[19:18];

   // =========================================
   // endianness set
   assign isEndianSet = (ins[31:16] == 16'hF101) && !ins[4];

   assign chk.endianUndef = isEndianSet && (ins[7] || ins[6]);

   // =========================================
   // reciprocal and reciprocal square root estimates
   assign isRecipEst = (ins[31:23] == 9'h1E7) && (ins[21:20] == 2'h3)
                       && (ins[17:16] == 2'h3) && (ins[11:9] == 3'h2) && !ins[4];

   assign chk.recipUndef = isRecipEst &&
                           ((size == 2'h0) || (size == 2'h3) ||
                            ((size == 2'h1) && (!chk.fp16Present || !ins[8])));

   // =========================================
   // data-independent-timing subsets
   assign isMiscCmp = (ins[31:23] == 9'h1E7) && (ins[21:20] == 2'h3)
                      && (ins[17:16] == 2'h1) && !ins[11] && !ins[4]
                      && ((ins[9:7] == 3'h0) || (ins[9:7] == 3'h1)
                          || (ins[9:7] == 3'h3) || (ins[9:7] == 3'h4)
                          || (ins[9:7] == 3'h6) || (ins[9:7] == 3'h7));
   assign isMlaScalar = (ins[31:25] == 7'h79) && ins[23] && (ins[21:20] != 2'h3)
                        && !ins[11] && !ins[9] && ins[6] && !ins[4];
   assign isAbdInt = (ins[31:25] == 7'h79) && !ins[23] && (ins[11:8] == 4'h7)
                     && !ins[4];

   assign chk.ditSubset1 = isAbdInt;

   assign chk.ditSubset2 = (isMiscCmp && !ins[10]) || (isMlaScalar && !ins[8]);
endmodule

/* File: design/simd_fp_decode_classifier.sv */
// instruction class decoder for the system, vector and floating-point space
// Summary of operation
// - unconditional primary opcode is taken from bits 26 down to 24.
// - primary 00x gives miscellaneous, 01x gives vector data-processing.
// - primary 1xx other than 101, with secondary 1, gives memory hints and barriers.
// - secondary 0: 100 vector load/store, 11x unallocated; 101 always unallocated.
// - tertiary opcode in the system/vector/FP space is bits 11 and 10.
// - primary 0, secondary 0x, tertiary 1x: register load/store and 64-bit move.
// - primary 0, secondary 10: FP data-processing, unallocated, or 32-bit move.
// - primary 1, secondary not 11, tertiary 1x: additional vector/FP group.
// - condition 1111, primary not 11, secondary 1x: unconditional vector/FP.
// - conditional form uses secondary as tertiary; primary 11 is supervisor call.
// - endianness set undefined unless both mask bits are zero.
// - estimates undefined for size 00/11; size 01 needs half precision and F.
// - second timing subset applies only when condition passes and integer.
// - compares and selects leave first subset; absolute difference integer only.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module simd_fp_decode_classifier
#(
   parameter int ADDR_W = 4
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              instrValid,
   input  wire logic [31:0]       instr,
   input  wire logic              condPass,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrStb,
   input  wire logic              regRdStb,
   output logic [31:0]            regRdData,
   output logic                   decValid,
   output sfd_pkg::sfd_group_t    decGroup,
   output logic                   undefInstr,
   output logic                   ditApplies
);
   sfd_chk_if chk ();

   logic                fp16Present_q;
   logic                altMode_q;
   logic [15:0]         undefCnt_q;
   logic [15:0]         undefCnt_d;
   logic [31:0]         rdData_d;
   logic                decValid_q;
   sfd_pkg::sfd_group_t decGroup_q;
   sfd_pkg::sfd_group_t group_d;
   logic                undef_d;
   logic                dit_d;
   logic                undefInstr_q;
   logic                ditApplies_q;
   logic [31:0]         rdData_q;

   logic [3:0]          cond;
   logic                condAlways;
   logic [2:0]          uncPri;
   logic                uncSec;
   logic                isUncond;
   logic                isSysA;
   logic [1:0]          sysPri;
   logic [1:0]          sysSec;
   logic                sysTer;
   logic                isSysAlt;
   logic                altPri;
   logic [1:0]          altSec;
   logic [1:0]          altTer;
   logic                altQua;
   logic                wrCtrl;
   logic                wrUndef;

   // =========================================
   // special encodings checker
   // the checker sees the raw word; masking by mode is done below
   assign chk.instr       = instr;
   assign chk.fp16Present = fp16Present_q;

   sfd_special_check u_check
   (
      .chk (chk)
   );

   // =========================================
   // field extraction
   assign cond       = instr[sfd_pkg::SFD_COND_MSB:sfd_pkg::SFD_COND_LSB];
   assign condAlways = (cond == sfd_pkg::SFD_COND_ALWAYS);

   // the unconditional class needs bit 27 low and the system space needs
   // bits 27:26 high, so the two never overlap and need no priority
   // between them
   // three-bit primary
   assign uncPri   = instr[sfd_pkg::SFD_UNC_PRI_MSB:sfd_pkg::SFD_UNC_PRI_LSB];
   assign uncSec   = instr[sfd_pkg::SFD_UNC_SEC_BIT];
   assign isUncond = condAlways && !instr[27];

   // conditional form: primary bits 25:24, secondary 11:10, tertiary bit 4
   assign isSysA = (instr[27:26] == 2'h3);
   assign sysPri = instr[sfd_pkg::SFD_SYS_PRI_MSB:sfd_pkg::SFD_SYS_PRI_LSB];
   assign sysSec = instr[sfd_pkg::SFD_SYS_TER_MSB:sfd_pkg::SFD_SYS_TER_LSB];
   assign sysTer = instr[sfd_pkg::SFD_SYS_QUA_BIT];

   // alternate form: bits 31:29 and 27:26 all high mark the space, and the
   // primary is a single bit, so every other field moves one place down
   // tertiary from bits 11 and 10
   assign isSysAlt = (instr[31:29] == 3'h7) && (instr[27:26] == 2'h3);
   assign altPri   = instr[sfd_pkg::SFD_ALT_PRI_BIT];
   assign altSec   = instr[sfd_pkg::SFD_SYS_PRI_MSB:sfd_pkg::SFD_SYS_PRI_LSB];
   assign altTer   = instr[sfd_pkg::SFD_SYS_TER_MSB:sfd_pkg::SFD_SYS_TER_LSB];
   assign altQua   = instr[sfd_pkg::SFD_SYS_QUA_BIT];

   // =========================================
   // group decode
   // rows are tried in order; in the conditional and alternate forms an unallocated row
   // comes first because it cuts across the primary opcode, so later rows may ignore those codes;
   // words outside every row stay in the other group and are not undefined
   always_comb
   begin
      group_d = sfd_pkg::SFD_GRP_OTHER;
      if (altMode_q)
      begin
         if (isSysAlt)
         begin
            if ((altSec != 2'h3) && !altTer[1])
               group_d = sfd_pkg::SFD_GRP_UNALLOC;
            else if (altSec == 2'h3)
               group_d = sfd_pkg::SFD_GRP_SIMD_DP;
            else if (!altPri && !altSec[1])
               group_d = sfd_pkg::SFD_GRP_SYS_LDST64;
            else if (!altPri && altQua)
               group_d = sfd_pkg::SFD_GRP_XFER32;
            else if (!altPri && (altTer == 2'h2))
               group_d = sfd_pkg::SFD_GRP_FP_DP;
            else if (!altPri)
               group_d = sfd_pkg::SFD_GRP_UNALLOC;
            else
               group_d = sfd_pkg::SFD_GRP_ADD_SIMD_FP;
         end
      end
      else if (isUncond)
      begin
         if (uncPri[2:1] == 2'h0)
            group_d = sfd_pkg::SFD_GRP_MISC;
         else if (uncPri[2:1] == 2'h1)
            group_d = sfd_pkg::SFD_GRP_SIMD_DP;
         else if (uncPri == 3'h5)
            group_d = sfd_pkg::SFD_GRP_UNALLOC;
         else if (uncSec)
            group_d = sfd_pkg::SFD_GRP_HINT_BAR;
         else if (uncPri == 3'h4)
            group_d = sfd_pkg::SFD_GRP_SIMD_LDST;
         else
            group_d = sfd_pkg::SFD_GRP_UNALLOC;
      end
      else if (isSysA)
      begin
         if ((sysPri != 2'h3) && !sysSec[1])
            group_d = sfd_pkg::SFD_GRP_UNALLOC;
         else if (sysPri == 2'h3)
            group_d = sfd_pkg::SFD_GRP_SVC;
         else if (condAlways)
            group_d = sfd_pkg::SFD_GRP_UNC_SIMD_FP;
         else if (!sysPri[1])
            group_d = sfd_pkg::SFD_GRP_SYS_LDST64;
         else if (sysTer)
            group_d = sfd_pkg::SFD_GRP_XFER32;
         else if (sysSec == 2'h2)
            group_d = sfd_pkg::SFD_GRP_FP_DP;
         else
            group_d = sfd_pkg::SFD_GRP_UNALLOC;
      end
   end

   // the special checks only know the conditional form, so they are masked
   // while the alternate form is selected
   // single undefined indication
   assign undef_d = (group_d == sfd_pkg::SFD_GRP_UNALLOC) ||
                    (!altMode_q && (chk.endianUndef || chk.recipUndef));

   // the first subset holds whatever the condition; the second one only
   // counts for words that will really execute
   // condition gates second subset
   assign dit_d = !altMode_q && (chk.ditSubset1 || (chk.ditSubset2 && condPass));

   // =========================================
   // decode output stage
   // an idle cycle shows the other group with both flags low, so a stale
   // decode never reaches the execute stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         decValid_q   <= 1'b0;
         decGroup_q   <= sfd_pkg::SFD_GRP_OTHER;
         undefInstr_q <= 1'b0;
         ditApplies_q <= 1'b0;
      end
      else
      begin
         decValid_q   <= instrValid;
         decGroup_q   <= instrValid ? group_d : sfd_pkg::SFD_GRP_OTHER;
         undefInstr_q <= instrValid && undef_d;
         ditApplies_q <= instrValid && dit_d;
      end
   end

   // =========================================
   // control register
   // offset 0x0: bit 0 half precision present, bit 1 alternate form
   // offset 0x4: last group, undefined, timing and valid flags, read only
   // offset 0x8: saturating count of undefined words, any write clears it
   // unmapped offsets read as zero and drop writes
   // a mode change applies to the word taken on the following edge
   assign wrCtrl  = regWrStb && (regAddr == ADDR_W'(sfd_pkg::SFD_OFF_CTRL));
   assign wrUndef = regWrStb && (regAddr == ADDR_W'(sfd_pkg::SFD_OFF_UNDEF));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fp16Present_q <= sfd_pkg::SFD_CTRL_RESET[sfd_pkg::SFD_CTRL_FP16_BIT];
         altMode_q     <= sfd_pkg::SFD_CTRL_RESET[sfd_pkg::SFD_CTRL_MODE_BIT];
      end
      else if (wrCtrl)
      begin
         fp16Present_q <= regWrData[sfd_pkg::SFD_CTRL_FP16_BIT];
         altMode_q     <= regWrData[sfd_pkg::SFD_CTRL_MODE_BIT];
      end
   end

   // =========================================
   // undefined counter: a write clears, a same-cycle event still counts
   // the count stops at all ones rather than wrap, so software can tell an
   // overflow apart from a small count; the clear acts before the increment,
   // which leaves a count of one when both fall in the same cycle
   always_comb
   begin
      undefCnt_d = wrUndef ? sfd_pkg::SFD_UNDEF_CNT_RESET : undefCnt_q;
      if (undefInstr_q && (undefCnt_d != 16'hFFFF))
         undefCnt_d = undefCnt_d + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         undefCnt_q <= sfd_pkg::SFD_UNDEF_CNT_RESET;
      else
         undefCnt_q <= undefCnt_d;
   end

   // =========================================
   // read port, data in the cycle after the strobe
   // the data register falls back to zero when no read is made, so a value
   // only stands in the one cycle after its strobe
   always_comb
   begin
      rdData_d = 32'h0000_0000;
      if (regRdStb)
      begin
         if (regAddr == ADDR_W'(sfd_pkg::SFD_OFF_CTRL))
         begin
            rdData_d[sfd_pkg::SFD_CTRL_FP16_BIT] = fp16Present_q;
            rdData_d[sfd_pkg::SFD_CTRL_MODE_BIT] = altMode_q;
         end
         else if (regAddr == ADDR_W'(sfd_pkg::SFD_OFF_STATUS))
         begin
            rdData_d[sfd_pkg::SFD_STAT_GRP_LSB +: 4] = decGroup_q;
            rdData_d[sfd_pkg::SFD_STAT_UNDEF_BIT]    = undefInstr_q;
            rdData_d[sfd_pkg::SFD_STAT_DIT_BIT]      = ditApplies_q;
            rdData_d[sfd_pkg::SFD_STAT_VALID_BIT]    = decValid_q;
         end
         else if (regAddr == ADDR_W'(sfd_pkg::SFD_OFF_UNDEF))
            rdData_d[15:0] = undefCnt_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rdData_q <= 32'h0000_0000;
      else
         rdData_q <= rdData_d;
   end

   assign regRdData  = rdData_q;
   assign decValid   = decValid_q;
   assign decGroup   = decGroup_q;
   assign undefInstr = undefInstr_q;
   assign ditApplies = ditApplies_q;
endmodule

/* File: testbench/sfd_dec_props.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module sfd_dec_props
#(
   parameter int ADDR_W = 4
)
(
   input logic               clk,
   input logic               rst,
   input logic               instrValid,
   input logic [31:0]        instr,
   input logic               condPass,
   input logic [ADDR_W-1:0]  regAddr,
   input logic [31:0]        regWrData,
   input logic               regWrStb,
   input sfd_pkg::sfd_group_t decGroup,
   input logic               undefInstr,
   input logic               ditApplies
);
   logic       fp16Q;
   logic       modeQ;
   logic       sub1Q;
   wire        unc = instrValid && !modeQ && instr[31:27] == 5'h1E;
   wire        sys = instrValid && !modeQ && instr[27:26] == 2'h3;
   wire [2:0]  pri = instr[26:24];
   wire        sub1 = instrValid && !modeQ && instr[31:25] == 7'h79 && !instr[23]
                      && instr[11:8] == 4'h7 && !instr[4];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ====================================
   // shadow of the control register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fp16Q <= 1'b0;
         modeQ <= 1'b0;
      end
      else if (regWrStb && regAddr == sfd_pkg::SFD_OFF_CTRL)
      begin
         fp16Q <= regWrData[0];
         modeQ <= regWrData[1];
      end
   end
   always_ff @(posedge clk)
   begin
      sub1Q <= sub1;
   end
   // ====================================
   // decode properties
   chk_unc_misc : assert property (
      unc && pri[2:1] == 2'h0 |=> decGroup == sfd_pkg::SFD_GRP_MISC)
      else $error("misc group not decoded");
   chk_unc_hint : assert property (
      unc && pri[2] && pri != 3'h5 && instr[20] |=> decGroup == sfd_pkg::SFD_GRP_HINT_BAR)
      else $error("hint group not decoded");
   chk_unc_unalloc : assert property (
      unc && !instr[20] && pri inside {3'h5, 3'h6, 3'h7}
      |=> decGroup == sfd_pkg::SFD_GRP_UNALLOC && undefInstr)
      else $error("unallocated unconditional word missed");
   chk_sys_unalloc : assert property (
      sys && instr[25:24] != 2'h3 && !instr[11]
      |=> decGroup == sfd_pkg::SFD_GRP_UNALLOC && undefInstr)
      else $error("unallocated system word missed");
   chk_svc_call : assert property (
      sys && instr[25:24] == 2'h3 |=> decGroup == sfd_pkg::SFD_GRP_SVC)
      else $error("supervisor call not decoded");
   chk_unc_vecfp : assert property (
      sys && instr[31:28] == 4'hF && instr[25:24] != 2'h3 && instr[11]
      |=> decGroup == sfd_pkg::SFD_GRP_UNC_SIMD_FP)
      else $error("unconditional vector group not decoded");
   chk_endian_undef : assert property (
      instrValid && !modeQ && instr[31:16] == 16'hF101 && !instr[4]
      |=> undefInstr == $past(instr[7] || instr[6]))
      else $error("endian set undefined flag wrong");
   chk_recip_undef : assert property (
      instrValid && !modeQ && instr[31:23] == 9'h1E7 && instr[21:20] == 2'h3
      && instr[17:16] == 2'h3 && instr[11:9] == 3'h2 && !instr[4]
      |=> undefInstr == $past(instr[19:18] == 2'h0 || instr[19:18] == 2'h3
                              || (instr[19:18] == 2'h1 && (!fp16Q || !instr[8]))))
      else $error("estimate undefined flag wrong");
   chk_dit_first : assert property (
      sub1 |=> ditApplies)
      else $error("integer absolute difference not flagged");
   chk_dit_cond : assert property (
      ditApplies |-> sub1Q || $past(condPass))
      else $error("timing flag without condition pass");
endmodule
bind simd_fp_decode_classifier sfd_dec_props #(.ADDR_W(ADDR_W)) u_props (.clk, .rst,
   .instrValid, .instr, .condPass, .regAddr, .regWrData, .regWrStb, .decGroup,
   .undefInstr, .ditApplies);

/* File: testbench/sfd_fetch_model.sv */
// fetch stage model issuing one instruction word per request
`timescale 1ns/1ps
module sfd_fetch_model
(
   input  logic        clk,
   input  logic        rst,
   input  logic        go,
   input  logic [31:0] word,
   input  logic        cp,
   output logic        instrValid,
   output logic [31:0] instr,
   output logic        condPass
);
   // the word is scrambled between issues so a stale value never looks valid
   always_ff @(posedge clk)
   begin
      instrValid <= go && !rst;
      instr <= go ? word : ~instr;
      condPass <= cp;
   end
endmodule

/* File: testbench/tb_simd_fp_decode_classifier.sv */
// self-checking bench for the instruction class decoder
`timescale 1ns/1ps
module tb_simd_fp_decode_classifier;
   logic clk, rst, go, cp, instrValid, condPass, regWrStb, regRdStb;
   logic decValid, undefInstr, ditApplies;
   logic [31:0] w, instr, regWrData, regRdData;
   logic [3:0] regAddr;
   sfd_pkg::sfd_group_t decGroup;
   logic [37:0] tv[$];
   int miscompares, checks_done, nu;
   sfd_fetch_model u_fetch (.clk, .rst, .go, .word(w), .cp, .instrValid, .instr, .condPass);
   simd_fp_decode_classifier u_dut (.clk, .rst, .instrValid, .instr, .condPass, .regAddr,
      .regWrData, .regWrStb, .regRdStb, .regRdData, .decValid, .decGroup, .undefInstr,
      .ditApplies);
   function automatic logic [37:0] e(logic [31:0] x, logic [3:0] g, logic u, logic d);
      return {x, g, u, d};
   endfunction
   function automatic logic [31:0] est(logic [1:0] s, logic f);
      return {9'h1E7, 1'b0, 2'h3, s, 2'h3, 4'h0, 3'h2, f, 8'h00};
   endfunction
   task cmp(input logic [31:0] g, input logic [31:0] x, input string m);
      checks_done++;
      if (g !== x)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, g, x);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdStb <= 1'b0;
      #1 cmp(regRdData, x, "register read");
   endtask
   // words go out back to back; each result is checked two edges later
   task run(input string name);
      for (int i = 0; i < tv.size() + 2; i++)
      begin
         @(posedge clk);
         go <= i < tv.size();
         w <= (i < tv.size()) ? tv[i][37:6] : 32'h0000_0000;
         cp <= i[0];
         #1;
         if (i >= 2)
         begin
            nu += tv[i-2][1];
            cmp({decValid, decGroup, undefInstr, ditApplies}, {1'b1, tv[i-2][5:0]}, name);
         end
      end
      tv.delete();
      $display("test %s done", name);
   endtask
   task end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #100000;
      miscompares++;
      end_sim;
   end
   initial
   begin
      {rst, go, cp, regWrStb, regRdStb, w, regWrData, regAddr} = '0;
      rst = 1;
      miscompares = 0;
      checks_done = 0;
      nu = 0;
      repeat (16) @(posedge clk);
      rst <= 0;
      rd(4'h0, 0);
      rd(4'h8, 0);
      rd(4'hC, 0);
      @(posedge clk);
      go <= 1'b1;
      w <= 32'hF200_0700;
      rd(4'h0, 0);
      rd(4'h4, 32'h0000_0062);
      tv = '{e(32'hF000_0000, 1, 0, 0), e(32'hF300_0000, 2, 0, 0),
         e(32'hF410_0000, 3, 0, 0), e(32'hF610_0000, 3, 0, 0),
         e(32'hF400_0000, 4, 0, 0), e(32'hF500_0000, 5, 1, 0),
         e(32'hF600_0000, 5, 1, 0), e(32'hEC00_0000, 5, 1, 0),
         e(32'hEE00_0400, 5, 1, 0), e(32'hEF00_0000, 11, 0, 0),
         e(32'hFF00_0C10, 11, 0, 0), e(32'hFC00_0800, 10, 0, 0),
         e(32'hEC00_0C00, 6, 0, 0), e(32'hEE00_0800, 7, 0, 0),
         e(32'hEE00_0C00, 5, 1, 0), e(32'hEE00_0C10, 8, 0, 0),
         e(32'hF101_0000, 1, 0, 0), e(32'hF101_0080, 1, 1, 0),
         e(32'hF101_0040, 1, 1, 0), e(32'hF200_0700, 2, 0, 1),
         e(32'hF200_0710, 2, 0, 0), e(32'hF280_0700, 2, 0, 0),
         e(est(1, 1), 2, 1, 0), e(est(2, 0), 2, 0, 0),
         e(est(0, 1), 2, 1, 0), e(est(3, 1), 2, 1, 0)};
      run("conditional form");
      rd(4'h8, nu);
      wr(4'h8, 32'h0000_0001);
      rd(4'h8, 0);
      wr(4'h0, 32'h0000_0001);
      rd(4'h0, 1);
      tv = '{e(est(1, 1), 2, 0, 0), e(est(1, 0), 2, 1, 0), e(est(2, 1), 2, 0, 0),
         e(32'hF3B9_0000, 2, 0, 1), e(32'hF3B9_0000, 2, 0, 0),
         e(32'hF3B9_0400, 2, 0, 0)};
      run("half precision");
      wr(4'h0, 32'h0000_0002);
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'h0, 2);
      tv = '{e(32'hEC00_0000, 5, 1, 0), e(32'hEE00_0000, 5, 1, 0),
         e(32'hEF00_0000, 2, 0, 0), e(32'hEC00_0800, 6, 0, 0),
         e(32'hEE00_0800, 7, 0, 0), e(32'hEE00_0C00, 5, 1, 0),
         e(32'hEE00_0810, 8, 0, 0), e(32'hFD00_0800, 9, 0, 0),
         e(32'hFF00_0800, 2, 0, 0)};
      run("alternate form");
      end_sim;
   end
endmodule
